/* hdl/vodf_pkg.sv */
// package: constants and types of the valve output diagnostic block
// Notes on behaviour
// - fieldbus parameter writes refused; terminal writes accepted, threshold only within 1..65000
// - priority selects switches or terminal fault modes
// - control supply error outside 20..26 V
// - output supply error outside 21..26 V (code also raises it on control supply high)
// - valve short raises unit error when enabled
// - short error auto clears or holds until power or detection disable
// - open circuit raises channel error when enabled
// - comm fault: off, hold or force on
// - terminal fault mode only under terminal priority
// - count ON events; error above threshold x1000
// - save counts every 30 s, resume after power
package vodf_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int          ADDR_W         = 8;
  localparam logic [7:0]  ADDR_CTRL      = 8'h00;
  localparam logic [7:0]  ADDR_COMM_FAULT_OUTPUT_MODE  = 8'h04;
  localparam logic [7:0]  ADDR_THRESH    = 8'h08;
  localparam logic [7:0]  ADDR_STATUS    = 8'h0C;
  localparam logic [7:0]  ADDR_IRQ_STAT  = 8'h10;
  localparam logic [7:0]  ADDR_IRQ_MASK  = 8'h14;
  localparam logic [7:0]  ADDR_OPEN_ERR  = 8'h18;
  localparam logic [7:0]  ADDR_CNT_ERR   = 8'h1C;
  localparam logic [7:0]  ADDR_COUNT0    = 8'h20;

  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cnt_err_en;
    logic prio_handheld;
    logic open_circuit_detect_en;
    logic short_error_restart_mode;
    logic valve_short_detect_en;
    logic output_supply_monitor_en;
    logic control_supply_monitor_en;
  } vodf_ctrl_s;
  localparam int          CTRL_W         = 7;
  localparam vodf_ctrl_s  CTRL_RST       = 7'h07;

  typedef enum logic [1:0] {
    FM_CLEAR = 2'b00,
    FM_HOLD  = 2'b01,
    FM_ON    = 2'b10
  } vodf_fault_e;

  localparam logic [15:0] THRESH_RST     = 16'h0001;
  localparam logic [15:0] THRESH_MIN     = 16'h0001;
  localparam logic [15:0] THRESH_MAX     = 16'hFDE8;
  localparam logic [15:0] CNT_MULT       = 16'h03E8;

  // status / interrupt bit positions
  localparam int          ST_CTRL_SUP    = 0;
  localparam int          ST_OUT_SUP     = 1;
  localparam int          ST_SHORT       = 2;
  localparam int          ST_OPEN        = 3;
  localparam int          ST_CNT         = 4;
  localparam int          ST_W           = 5;

  localparam logic [1:0]  RESP_OKAY      = 2'b00;
  localparam logic [1:0]  RESP_SLVERR    = 2'b10;
  localparam logic [1:0]  RESP_DECERR    = 2'b11;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int          CLK_HZ         = 20_000_000;
  localparam int          SAVE_TIME_S    = 30;
  localparam int          SAVE_CYCLES    = SAVE_TIME_S * CLK_HZ;

endpackage : vodf_pkg

/* hdl/vodf_top.sv */
// module: valve output diagnostics, fail-safe outputs and ON counters
`timescale 1ns/1ps
module vodf_top
  import vodf_pkg::*;
#(
  parameter int CH          = 8,
  parameter int SAVE_PERIOD = SAVE_CYCLES
) (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic                ce,
  input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  input  wire logic                cfg_from_terminal,
  input  wire logic [2*CH-1:0]     switch_fault_mode,
  input  wire logic                comm_fault,
  input  wire logic [CH-1:0]       valve_cmd,
  input  wire logic                supply_ctrl_high,
  input  wire logic                supply_ctrl_low,
  input  wire logic                supply_out_high,
  input  wire logic                supply_out_low,
  input  wire logic                valve_short,
  input  wire logic [CH-1:0]       valve_open,
  input  wire logic [32*CH-1:0]    nv_restore_cnt,
  output logic [CH-1:0]            valve_out,
  output logic                     err_ctrl_supply,
  output logic                     err_out_supply,
  output logic                     err_short,
  output logic [CH-1:0]            err_open,
  output logic [CH-1:0]            err_count,
  output logic                     nv_save_stb,
  output logic [32*CH-1:0]         nv_save_cnt,
  output logic                     irq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  vodf_ctrl_s        ctrl,      next_ctrl;
  logic [2*CH-1:0]   fmode,     next_fmode;
  logic [15:0]       thresh,    next_thresh;
  logic [ST_W-1:0]   irq_stat,  next_irq_stat;
  logic [ST_W-1:0]   irq_mask,  next_irq_mask;
  logic [31:0]       cnt [CH],  next_cnt [CH];
  logic              restore_pend, next_restore_pend;
  logic [31:0]       save_tmr,  next_save_tmr;
  logic [CH-1:0]     next_valve_out, next_err_open, next_err_count;
  logic              next_err_ctrl, next_err_out, next_err_short;
  logic              next_nv_save_stb, next_irq;
  logic [32*CH-1:0]  next_nv_save_cnt;
  logic              aw_have, next_aw_have, w_have, next_w_have;
  logic [ADDR_W-1:0] waddr,     next_waddr;
  logic [31:0]       wdata,     next_wdata;
  logic [3:0]        wstrb,     next_wstrb;
  logic              next_bvalid, next_rvalid;
  logic [1:0]        next_bresp, next_rresp;
  logic [31:0]       next_rdata;
  logic              do_wr;
  logic [31:0]       wmask;
  logic [31:0]       limit;
  logic [ST_W-1:0]   live, live_d;
  logic [1:0]        eff_mode [CH];

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction : merge

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic [31:0] tmp;
    logic [15:0] th;
    tmp = 32'h0000_0000;
    th  = 16'h0000;
    next_ctrl         = ctrl;
    next_fmode        = fmode;
    next_thresh       = thresh;
    next_irq_mask     = irq_mask;
    next_restore_pend = 1'b0;
    next_aw_have      = aw_have;
    next_w_have       = w_have;
    next_waddr        = waddr;
    next_wdata        = wdata;
    next_wstrb        = wstrb;
    next_bvalid       = s_axi_bvalid;
    next_bresp        = s_axi_bresp;
    next_rvalid       = s_axi_rvalid;
    next_rresp        = s_axi_rresp;
    next_rdata        = s_axi_rdata;
    wmask = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};
    do_wr = aw_have && w_have && !s_axi_bvalid;
    limit = 32'(thresh) * 32'(CNT_MULT);

    // write channels taken in either order, one write under way
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_have = 1'b1;
      next_waddr   = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_have = 1'b1;
      next_wdata  = s_axi_wdata;
      next_wstrb  = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end

    // live error flags
    next_err_ctrl = ctrl.control_supply_monitor_en &&
                    (supply_ctrl_high || supply_ctrl_low);
    next_err_out  = ctrl.output_supply_monitor_en &&
                    (supply_ctrl_high || supply_out_high ||
                     supply_out_low);
    if (!ctrl.valve_short_detect_en) begin
      next_err_short = 1'b0;
    end else if (valve_short) begin
      next_err_short = 1'b1;
    end else begin
      // manual restart keeps the error until the next reset or until detection is disabled
      next_err_short = ctrl.short_error_restart_mode && err_short;
    end

    for (int i = 0; i < CH; i++) begin
      eff_mode[i] = ctrl.prio_handheld ? fmode[2*i +: 2]
                                       : switch_fault_mode[2*i +: 2];
      if (!comm_fault) begin
        next_valve_out[i] = valve_cmd[i];
      end else begin
        unique case (eff_mode[i])
          FM_CLEAR: next_valve_out[i] = 1'b0;
          FM_HOLD:  next_valve_out[i] = valve_out[i];
          FM_ON:    next_valve_out[i] = 1'b1;
          default:  next_valve_out[i] = 1'b0;
        endcase
      end
      next_err_open[i] = ctrl.open_circuit_detect_en && valve_open[i];
      next_cnt[i] = cnt[i];
      if (restore_pend) begin
        next_cnt[i] = nv_restore_cnt[32*i +: 32];
      end else if (next_valve_out[i] && !valve_out[i] &&
                   cnt[i] != 32'hFFFF_FFFF) begin
        next_cnt[i] = cnt[i] + 32'h0000_0001;
      end
      next_err_count[i] = ctrl.cnt_err_en && (cnt[i] > limit);
    end

    // periodic snapshot toward retained storage
    next_nv_save_stb = 1'b0;
    next_nv_save_cnt = nv_save_cnt;
    next_save_tmr    = save_tmr + 32'h0000_0001;
    if (save_tmr >= 32'(SAVE_PERIOD - 1)) begin
      next_save_tmr    = 32'h0000_0000;
      next_nv_save_stb = 1'b1;
      for (int i = 0; i < CH; i++) begin
        next_nv_save_cnt[32*i +: 32] = cnt[i];
      end
    end

    // interrupt events are rising edges of the error summary
    live = {|err_count, |err_open, err_short, err_out_supply,
            err_ctrl_supply};
    next_irq_stat = irq_stat;

    if (do_wr) begin
      next_aw_have = 1'b0;
      next_w_have  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = RESP_OKAY;
      unique case (waddr)
        ADDR_CTRL, ADDR_COMM_FAULT_OUTPUT_MODE, ADDR_THRESH: begin
          if (!cfg_from_terminal) begin
            next_bresp = RESP_SLVERR;
          end else if (waddr == ADDR_CTRL) begin
            tmp       = merge(32'(ctrl), wdata, wmask);
            next_ctrl = tmp[CTRL_W-1:0];
          end else if (waddr == ADDR_COMM_FAULT_OUTPUT_MODE) begin
            tmp        = merge(32'(fmode), wdata, wmask);
            next_fmode = tmp[2*CH-1:0];
          end else begin
            tmp = merge(32'(thresh), wdata, wmask);
            th  = tmp[15:0];
            if (th < THRESH_MIN || th > THRESH_MAX) begin
              next_bresp = RESP_SLVERR;
            end else begin
              next_thresh = th;
            end
          end
        end
        ADDR_IRQ_STAT: begin
          tmp = wdata & wmask;
          next_irq_stat = irq_stat & ~tmp[ST_W-1:0];
        end
        ADDR_IRQ_MASK: begin
          tmp = merge(32'(irq_mask), wdata, wmask);
          next_irq_mask = tmp[ST_W-1:0];
        end
        ADDR_STATUS, ADDR_OPEN_ERR, ADDR_CNT_ERR: ;
        default: begin
          if (waddr < ADDR_COUNT0 ||
              waddr >= 8'(ADDR_COUNT0 + 4 * CH)) begin
            next_bresp = RESP_DECERR;
          end
        end
      endcase
    end
    // set wins over a clear in the same cycle
    next_irq_stat = next_irq_stat | (live & ~live_d);
    next_irq      = |(next_irq_stat & next_irq_mask);

    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = RESP_OKAY;
      next_rdata  = 32'h0000_0000;
      unique case (s_axi_araddr)
        ADDR_CTRL:     next_rdata = 32'(ctrl);
        ADDR_COMM_FAULT_OUTPUT_MODE: next_rdata = 32'(fmode);
        ADDR_THRESH:   next_rdata = 32'(thresh);
        ADDR_STATUS:   next_rdata = 32'(live);
        ADDR_IRQ_STAT: next_rdata = 32'(irq_stat);
        ADDR_IRQ_MASK: next_rdata = 32'(irq_mask);
        ADDR_OPEN_ERR: next_rdata = 32'(err_open);
        ADDR_CNT_ERR:  next_rdata = 32'(err_count);
        default: begin
          next_rresp = RESP_DECERR;
          for (int i = 0; i < CH; i++) begin
            if (s_axi_araddr == 8'(ADDR_COUNT0 + 4 * i)) begin
              next_rdata = cnt[i];
              next_rresp = RESP_OKAY;
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl            <= CTRL_RST;
      fmode           <= '0;
      thresh          <= THRESH_RST;
      irq_stat        <= '0;
      irq_mask        <= '0;
      restore_pend    <= 1'b1;
      save_tmr        <= 32'h0000_0000;
      for (int i = 0; i < CH; i++) cnt[i] <= 32'h0000_0000;
      valve_out       <= '0;
      err_ctrl_supply <= 1'b0;
      err_out_supply  <= 1'b0;
      err_short       <= 1'b0;
      err_open        <= '0;
      err_count       <= '0;
      nv_save_stb     <= 1'b0;
      nv_save_cnt     <= '0;
      irq             <= 1'b0;
      live_d          <= '0;
      aw_have         <= 1'b0;
      w_have          <= 1'b0;
      waddr           <= '0;
      wdata           <= 32'h0000_0000;
      wstrb           <= 4'h0;
      s_axi_awready   <= 1'b0;
      s_axi_wready    <= 1'b0;
      s_axi_bvalid    <= 1'b0;
      s_axi_bresp     <= RESP_OKAY;
      s_axi_arready   <= 1'b0;
      s_axi_rvalid    <= 1'b0;
      s_axi_rresp     <= RESP_OKAY;
      s_axi_rdata     <= 32'h0000_0000;
    end else if (ce) begin
      ctrl            <= next_ctrl;
      fmode           <= next_fmode;
      thresh          <= next_thresh;
      irq_stat        <= next_irq_stat;
      irq_mask        <= next_irq_mask;
      restore_pend    <= next_restore_pend;
      save_tmr        <= next_save_tmr;
      for (int i = 0; i < CH; i++) cnt[i] <= next_cnt[i];
      valve_out       <= next_valve_out;
      err_ctrl_supply <= next_err_ctrl;
      err_out_supply  <= next_err_out;
      err_short       <= next_err_short;
      err_open        <= next_err_open;
      err_count       <= next_err_count;
      nv_save_stb     <= next_nv_save_stb;
      nv_save_cnt     <= next_nv_save_cnt;
      irq             <= next_irq;
      live_d          <= live;
      aw_have         <= next_aw_have;
      w_have          <= next_w_have;
      waddr           <= next_waddr;
      wdata           <= next_wdata;
      wstrb           <= next_wstrb;
      // ready only while the holding slot is empty
      s_axi_awready   <= !next_aw_have && !next_bvalid;
      s_axi_wready    <= !next_w_have && !next_bvalid;
      s_axi_bvalid    <= next_bvalid;
      s_axi_bresp     <= next_bresp;
      s_axi_arready   <= !next_rvalid;
      s_axi_rvalid    <= next_rvalid;
      s_axi_rresp     <= next_rresp;
      s_axi_rdata     <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  cfg_refuse_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && do_wr && !cfg_from_terminal |=> ctrl == $past(ctrl) &&
    fmode == $past(fmode) && s_axi_bvalid)
    else $error("parameter write from fieldbus was taken");
  switch_prio_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && comm_fault && !ctrl.prio_handheld &&
    switch_fault_mode[1:0] == FM_ON |=> valve_out[0])
    else $error("switch fault mode not obeyed");
  term_mode_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && comm_fault && ctrl.prio_handheld && fmode[1:0] == FM_CLEAR
    |=> !valve_out[0])
    else $error("terminal fault mode not obeyed");
  ctrl_sup_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ce |=> err_ctrl_supply == ($past(ctrl.control_supply_monitor_en) &&
    ($past(supply_ctrl_high) || $past(supply_ctrl_low))))
    else $error("control supply error wrong");
  out_sup_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && ctrl.output_supply_monitor_en && supply_out_low
    |=> err_out_supply)
    else $error("output supply error missing");
  short_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && !ctrl.valve_short_detect_en |=> !err_short)
    else $error("short error while detection disabled");
  short_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && err_short && ctrl.valve_short_detect_en &&
    ctrl.short_error_restart_mode |=> err_short)
    else $error("manual short error cleared");
  short_auto_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && !valve_short && !ctrl.short_error_restart_mode |=> !err_short)
    else $error("auto short error not cleared");
  open_det_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && ctrl.open_circuit_detect_en && valve_open[0] |=> err_open[0])
    else $error("open circuit error missing");
  hold_out_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && comm_fault && eff_mode[0] == FM_HOLD |=> $stable(valve_out[0]))
    else $error("held output changed");
  cnt_err_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && ctrl.cnt_err_en && cnt[0] > limit |=> err_count[0])
    else $error("count error missing");
  save_pulse_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && $rose(nv_save_stb) |-> nv_save_cnt[31:0] == $past(cnt[0]) ##1
    !nv_save_stb)
    else $error("save snapshot wrong");
  irq_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ce ##1 ce |-> irq == |(irq_stat & irq_mask))
    else $error("interrupt level wrong");

endmodule : vodf_top

/* testbench/vodf_top_tb.sv */
// testbench: register, diagnostic and fail-safe scenarios
`timescale 1ns/1ps
module vodf_top_tb;
  import vodf_pkg::*;
  localparam int CH = 8;
  logic             aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
  logic [7:0]       s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0]      s_axi_wdata = '0, s_axi_rdata, d;
  logic [3:0]       s_axi_wstrb = 4'hF;
  logic             s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic             s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic             s_axi_rready = 1'b0, cfg_from_terminal = 1'b0;
  logic             comm_fault = 1'b0, supply_ctrl_high = 1'b0;
  logic             supply_ctrl_low = 1'b0, supply_out_high = 1'b0;
  logic             supply_out_low = 1'b0, short_on = 1'b0;
  logic [2*CH-1:0]  switch_fault_mode = '0;
  logic [CH-1:0]    valve_cmd = '0, open_mask = '0, valve_open;
  logic [CH-1:0]    valve_out, err_open, err_count;
  logic             s_axi_awready, s_axi_wready, s_axi_bvalid, irq;
  logic             s_axi_arready, s_axi_rvalid, err_ctrl_supply;
  logic             err_out_supply, err_short, nv_save_stb, valve_short;
  logic [1:0]       s_axi_bresp, s_axi_rresp, r;
  logic [32*CH-1:0] nv_save_cnt, nv_restore_cnt;
  int               miscompares = 0, num_checks = 0;

  always #25 aclk = ~aclk;

  // short save period keeps the run brief
  vodf_top #(.CH(CH), .SAVE_PERIOD(50)) i_vodf_top (.aclk, .aresetn, .ce,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .cfg_from_terminal, .switch_fault_mode, .comm_fault,
    .valve_cmd, .supply_ctrl_high, .supply_ctrl_low, .supply_out_high,
    .supply_out_low, .valve_short, .valve_open, .nv_restore_cnt,
    .valve_out, .err_ctrl_supply, .err_out_supply, .err_short, .err_open,
    .err_count, .nv_save_stb, .nv_save_cnt, .irq);
  vodf_valve_model #(.CH(CH)) i_vodf_valve_model (.aclk, .short_on,
    .open_mask, .nv_save_stb, .nv_save_cnt, .valve_short, .valve_open,
    .nv_restore_cnt);

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : final_report
  task automatic hang();
    $display("BAD %0t wait timed out", $time);
    miscompares++;
    final_report();
  endtask : hang
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wc(input int n);
    repeat (n) @(posedge aclk);
  endtask : wc
  task automatic rst();
    aresetn <= 1'b0;
    wc(2);
    aresetn <= 1'b1;
  endtask : rst
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    repeat (40) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        return;
      end
    end
    hang();
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    repeat (40) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        return;
      end
    end
    hang();
  endtask : rd

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    rd(ADDR_CTRL); chk(d, 32'h0000_0007);
    rd(ADDR_THRESH); chk(d, 32'h0000_0001);
    rd(ADDR_IRQ_MASK); chk(d, 32'h0000_0000);
    rd(8'h40); chk(32'(r), 32'(RESP_DECERR));
    wr(ADDR_CTRL, 32'h0); chk(32'(r), 32'(RESP_SLVERR));
    rd(ADDR_CTRL); chk(d, 32'h0000_0007);
    cfg_from_terminal <= 1'b1;
    wr(ADDR_THRESH, 32'h0); chk(32'(r), 32'(RESP_SLVERR));
    wr(ADDR_THRESH, 32'hFDE9); chk(32'(r), 32'(RESP_SLVERR));
    wr(ADDR_THRESH, 32'hFDE8); chk(32'(r), 32'(RESP_OKAY));
    rd(ADDR_THRESH); chk(d, 32'h0000_FDE8);
    wr(ADDR_THRESH, 32'h1);
  endtask : t_regs
  task automatic t_supply();
    wr(ADDR_IRQ_MASK, 32'h1);
    supply_ctrl_high <= 1'b1;
    wc(4); chk(32'(err_ctrl_supply), 32'h1);
    chk(32'(irq), 32'h1);
    wr(ADDR_IRQ_STAT, 32'h1);
    wc(2); chk(32'(irq), 32'h0);
    supply_ctrl_high <= 1'b0;
    supply_ctrl_low <= 1'b1;
    wc(3); chk(32'(err_ctrl_supply), 32'h1);
    wr(ADDR_CTRL, 32'h6);
    wc(3); chk(32'(err_ctrl_supply), 32'h0);
    supply_ctrl_low <= 1'b0;
    supply_out_low <= 1'b1;
    wc(3); chk(32'(err_out_supply), 32'h1);
    wr(ADDR_CTRL, 32'h5);
    wc(3); chk(32'(err_out_supply), 32'h0);
    supply_out_low <= 1'b0;
  endtask : t_supply
  task automatic t_diag();
    wr(ADDR_CTRL, 32'h7);
    short_on <= 1'b1;
    wc(4); chk(32'(err_short), 32'h1);
    short_on <= 1'b0;
    wc(4); chk(32'(err_short), 32'h0);
    wr(ADDR_CTRL, 32'hF);
    short_on <= 1'b1;
    wc(4);
    short_on <= 1'b0;
    wc(4); chk(32'(err_short), 32'h1);
    wr(ADDR_CTRL, 32'h3);
    short_on <= 1'b1;
    wc(4); chk(32'(err_short), 32'h0);
    short_on <= 1'b0;
    open_mask <= 8'h81;
    wc(4); chk(32'(err_open), 32'h0);
    wr(ADDR_CTRL, 32'h17);
    wc(4); chk(32'(err_open), 32'h81);
    rd(ADDR_OPEN_ERR); chk(d, 32'h81);
    open_mask <= '0;
  endtask : t_diag
  task automatic t_count();
    int i;
    wr(ADDR_CTRL, 32'h47);
    for (i = 0; i < 1001; i++) begin
      valve_cmd[0] <= 1'b1;
      wc(1);
      valve_cmd[0] <= 1'b0;
      wc(1);
      if (i == 999) begin
        wc(3); chk(32'(err_count), 32'h0);
      end
    end
    wc(3); chk(32'(err_count), 32'h1);
    rd(ADDR_COUNT0); chk(d, 32'h3E9);
    i = 0;
    while (nv_save_stb !== 1'b1) begin
      wc(1);
      if (++i > 60) hang();
    end
    chk(nv_save_cnt[31:0], 32'h3E9);
    wc(2);
    rst();
    rd(ADDR_COUNT0); chk(d, 32'h3E9);
  endtask : t_count
  task automatic t_fault();
    // switches: ch0 on, ch1 hold, ch2 off, ch3 code 11 (off)
    switch_fault_mode <= 16'h00C6;
    valve_cmd <= 8'h06;
    wc(3); chk(32'(valve_out), 32'h06);
    comm_fault <= 1'b1;
    valve_cmd <= 8'h09;
    wc(3); chk(32'(valve_out), 32'h03);
    wr(ADDR_COMM_FAULT_OUTPUT_MODE, 32'h21);
    wc(3); chk(32'(valve_out), 32'h03);
    wr(ADDR_CTRL, 32'h27);
    wc(3); chk(32'(valve_out), 32'h05);
    wr(ADDR_COMM_FAULT_OUTPUT_MODE, 32'h20);
    wc(3); chk(32'(valve_out), 32'h04);
    comm_fault <= 1'b0;
    wc(3); chk(32'(valve_out), 32'h09);
    // a low clock enable must freeze the outputs
    ce <= 1'b0;
    valve_cmd <= 8'h00;
    wc(3); chk(32'(valve_out), 32'h09);
    ce <= 1'b1;
    wc(3); chk(32'(valve_out), 32'h00);
  endtask : t_fault

  initial begin
    rst();
    t_regs();
    t_supply();
    t_diag();
    t_count();
    t_fault();
    final_report();
  end
endmodule : vodf_top_tb

/* testbench/vodf_valve_model.sv */
// model: valve detectors and retained count storage beside the block
`timescale 1ns/1ps
module vodf_valve_model #(
  parameter int CH = 8
) (
  input  wire logic            aclk,
  input  wire logic            short_on,
  input  wire logic [CH-1:0]   open_mask,
  input  wire logic            nv_save_stb,
  input  wire logic [32*CH-1:0] nv_save_cnt,
  output logic                 valve_short,
  output logic [CH-1:0]        valve_open,
  output logic [32*CH-1:0]     nv_restore_cnt
);
  // ----------------------------------------------------------------
  // detectors and storage
  // ----------------------------------------------------------------
  // storage is not cleared by the block's reset, as retained memory
  initial begin
    valve_short = 1'b0;
    valve_open = '0;
    nv_restore_cnt = '0;
  end
  always @(posedge aclk) begin
    valve_short <= short_on;
    valve_open <= open_mask;
    if (nv_save_stb) nv_restore_cnt <= nv_save_cnt;
  end
endmodule : vodf_valve_model
